/* File: core/oem_ctrl.sv */
`timescale 1ns/10ps
`include "oem_cfg.svh"

// How it works
// R1: Power up output off, setpoint shown, unless autorecovery.
// R2: Analog remote at power-up enables output unless inhibited.
// R3: Setpoints start zero/minimum, or saved when recall set.
// R4: Current setpoint never below model minimum once running.
// R5: Mode-select not grounded: local, display blank.
// R6: Accepted digital command enters digital remote, except unlock during analog remote; panel ignored.
// R7: Both knobs return local until next command.
// R8: Grounded mode-select: analog remote; both knobs end it.
// R9: Analog remote rejects commands except panel unlock and calibration.
// R10: Calibration during analog remote forces digital remote.
// R11: Inhibit stays active in local and digital.
// R12: Lock switch at power-up locks panel, three indications.
// R13: Unlock command, or power-up with lock switch off, releases lockout.
// R14: Menu ignored in setpoint mode; knob tap leaves it.
// R15: Menu: rotate scrolls, output selects, back, exit.
// R16: Coarse/fine knob behaviour swapped by stored preference.
// R17: Accepted preference shows wait, then preference item.
// R18: Outside setpoint and menu modes output switch toggles output.
// R19: Setpoint mode never enables; may disable output.
// R20: Inhibit polarity programmable; open pin per polarity.
// R21: Local inhibit forces off; press ignored, flashes once.
// R22: Digital inhibit overrides on; rejection flashes every two seconds.
// R23: Analog: inhibit switches enabled output; none when off.
// R24: Inhibit and mode-select pass two synchroniser stages.
module oem_ctrl
  import oem_pkg::*;
#(
  parameter int unsigned REP_CYC = `OEM_REP_MS * `OEM_CLK_KHZ,
  parameter int unsigned FLASH_CYC = `OEM_FLASH_MS * `OEM_CLK_KHZ,
  parameter int unsigned WAIT_CYC = `OEM_WAIT_MS * `OEM_CLK_KHZ,
  parameter logic [`OEM_SPW-1:0] MIN_CURR = `OEM_MIN_CURR
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire oem_panel_type PANEL_I,
  input wire oem_strap_type STRAP_I,
  input wire logic MODE_SEL_I,
  input wire logic INHIBIT_INPUT_I,
  input wire logic [`OEM_AW-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic OUT_EN_O,
  output oem_mode_type MODE_O,
  output oem_disp_type DISP_O,
  output logic PREF_SHOWN_O,
  output logic [`OEM_SPW-1:0] VSET_O,
  output logic [`OEM_SPW-1:0] ISET_O
);

  oem_state_type s_reg;
  oem_state_type s_next;
  oem_status_type stat;
  logic inh;
  logic fire;
  logic cmd_hit;
  logic cmd_acc;
  logic is_cal;
  logic is_unlock;
  logic panel_ok;
  logic adj_go;
  logic [`OEM_CMDW-1:0] code;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [`OEM_SPW-1:0] step_adj(input logic [`OEM_SPW-1:0] val,
                                                   input logic up, input logic fine);
    logic [`OEM_SPW:0] sum;
    logic [`OEM_SPW-1:0] st;
    begin
      st = fine ? `OEM_FINE_STEP : `OEM_COARSE_STEP;
      sum = {1'b0, val} + {1'b0, st};
      if (up)
        step_adj = sum[`OEM_SPW] ? '1 : sum[`OEM_SPW-1:0];
      else
        step_adj = (val > st) ? val - st : `OEM_ZERO_SP;
    end
  endfunction

  function automatic logic [`OEM_SPW-1:0] clamp_curr(input logic [`OEM_SPW-1:0] val);
    begin
      clamp_curr = (val < MIN_CURR) ? MIN_CURR : val;
    end
  endfunction

  function automatic logic [`OEM_SPW-1:0] merge_sp(input logic [`OEM_SPW-1:0] old,
                                                   input logic [31:0] wd, input logic [3:0] be);
    begin
      merge_sp = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------------
  // Polarity 1 means a high pin inhibits, so an open pin pulled high keeps the output off.
  assign inh = s_reg.inh_pol ? s_reg.syn_inh2 : ~s_reg.syn_inh2; // see R20
  // A write lands only at the edge where waitrequest is seen low.
  assign fire = AVS_WRITE_I & s_reg.bus_done & (s_reg.phase == PH_RUN);
  assign code = AVS_WRITEDATA_I[`OEM_CMDW-1:0];
  assign cmd_hit = fire & ((AVS_ADDRESS_I == `OEM_REG_CMD) | (AVS_ADDRESS_I == `OEM_REG_VSET)
                           | (AVS_ADDRESS_I == `OEM_REG_ISET));
  assign is_cal = (AVS_ADDRESS_I == `OEM_REG_CMD) & (code == `OEM_CMD_CAL);
  assign is_unlock = (AVS_ADDRESS_I == `OEM_REG_CMD) & (code == `OEM_CMD_UNLOCK);
  assign cmd_acc = cmd_hit & ((s_reg.mode != MODE_ANALOG) | is_cal | is_unlock); // see R9
  assign panel_ok = (s_reg.phase == PH_RUN) & (s_reg.mode == MODE_LOCAL) & ~s_reg.locked;
  assign adj_go = panel_ok & PANEL_I.rot
                  & ((s_reg.ui == UI_SET) | ((s_reg.ui == UI_IDLE) & s_reg.out_req));

  assign stat = '{zero: '0, mode: s_reg.mode, out_en: s_reg.out_act, locked: s_reg.locked,
                  setpoint: (s_reg.ui == UI_SET), inhibit: inh, rep_flash: s_reg.rep_on,
                  pref_fine: s_reg.pref, inh_high: s_reg.inh_pol};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.syn_inh1 = INHIBIT_INPUT_I; // see R24
    s_next.syn_inh2 = s_reg.syn_inh1;
    s_next.syn_ms1 = MODE_SEL_I;
    s_next.syn_ms2 = s_reg.syn_ms1;

    // Bus slave: one wait state, read data captured while waitrequest is high.
    s_next.bus_done = (AVS_READ_I | AVS_WRITE_I) & ~s_reg.bus_done;
    if (AVS_READ_I & ~s_reg.bus_done)
    begin
      s_next.rdata = '0;
      case (AVS_ADDRESS_I)
        `OEM_REG_CTRL:
        begin
          s_next.rdata[`OEM_CTRL_INH_HIGH] = s_reg.inh_pol;
          s_next.rdata[`OEM_CTRL_PREF_FINE] = s_reg.pref;
        end
        `OEM_REG_STAT: s_next.rdata = stat;
        `OEM_REG_VSET: s_next.rdata[`OEM_SPW-1:0] = s_reg.vset;
        `OEM_REG_ISET: s_next.rdata[`OEM_SPW-1:0] = s_reg.iset;
        default: s_next.rdata = '0;
      endcase
    end

    if (s_reg.flash_cnt != '0)
      s_next.flash_cnt = s_reg.flash_cnt - 1'b1;
    if (s_reg.wait_cnt != '0)
      s_next.wait_cnt = s_reg.wait_cnt - 1'b1;
    if (s_reg.rep_on)
    begin
      if (s_reg.rep_cnt == `OEM_TW'(REP_CYC - 1))
      begin
        s_next.rep_cnt = '0;
        s_next.flash_cnt = `OEM_TW'(FLASH_CYC); // see R22
      end
      else
        s_next.rep_cnt = s_reg.rep_cnt + 1'b1;
    end

    case (s_reg.phase)
      PH_SETTLE: s_next.phase = PH_SYNC;
      PH_SYNC: s_next.phase = PH_BOOT;
      PH_BOOT:
      begin
        // The synchronised mode-select is valid here, two edges after the release.
        if (STRAP_I.self_test_ok)
        begin
          s_next.phase = PH_RUN;
          s_next.ui = UI_SET; // see R1
          s_next.locked = STRAP_I.sw_lock; // see R12
          s_next.vset = STRAP_I.sw_recall ? STRAP_I.saved_v : `OEM_ZERO_SP; // see R3
          s_next.iset = clamp_curr(STRAP_I.sw_recall ? STRAP_I.saved_i : `OEM_ZERO_SP); // see R4
          if (s_reg.syn_ms2)
          begin
            s_next.mode = MODE_LOCAL; // see R5
            s_next.out_req = STRAP_I.auto_rec; // see R1
          end
          else
          begin
            s_next.mode = MODE_ANALOG; // see R8
            s_next.arm = 1'b1; // see R2
          end
        end
      end
      PH_RUN:
      begin
        // Leaving a remote mode from the panel; analog remote cannot come back.
        if ((s_reg.phase == PH_RUN) & PANEL_I.both & ~s_reg.locked
            & (s_reg.mode != MODE_LOCAL))
        begin
          s_next.mode = MODE_LOCAL; // see R7
          if (s_reg.mode == MODE_ANALOG)
          begin
            s_next.out_req = s_reg.out_act; // see R8
            s_next.arm = 1'b0;
            s_next.ui = UI_IDLE;
          end
        end

        if (adj_go)
        begin
          if (PANEL_I.rot_curr)
            s_next.iset = clamp_curr(step_adj(s_reg.iset, PANEL_I.rot_up,
                                              PANEL_I.pushed ^ s_reg.pref)); // see R16
          else
            s_next.vset = step_adj(s_reg.vset, PANEL_I.rot_up, PANEL_I.pushed ^ s_reg.pref);
        end

        if (panel_ok)
        begin
          case (s_reg.ui)
            UI_SET:
            begin
              if (PANEL_I.vtap | PANEL_I.itap)
                s_next.ui = UI_IDLE; // see R14
              else if (PANEL_I.out_press)
                s_next.out_req = 1'b0; // see R19
            end
            UI_IDLE:
            begin
              if (PANEL_I.vtap | PANEL_I.itap)
                s_next.ui = UI_SET;
              else if (PANEL_I.menu_press)
              begin
                s_next.ui = UI_MENU;
                s_next.sel = 1'b0;
              end
              else if (PANEL_I.out_press)
              begin
                if (s_reg.out_req)
                  s_next.out_req = 1'b0; // see R18
                else if (inh)
                  s_next.flash_cnt = `OEM_TW'(FLASH_CYC); // see R21
                else
                  s_next.out_req = 1'b1;
              end
            end
            UI_MENU:
            begin
              if (PANEL_I.menu_press)
                s_next.ui = UI_IDLE; // see R15
              else if (PANEL_I.rot)
                s_next.sel = ~s_reg.sel;
              else if (PANEL_I.out_press)
              begin
                s_next.ui = s_reg.sel ? UI_IDLE : UI_UTILITY_MENU_ITEM;
                s_next.sel = 1'b0;
              end
            end
            UI_UTILITY_MENU_ITEM:
            begin
              if (PANEL_I.menu_press)
                s_next.ui = UI_IDLE; // see R15
              else if (PANEL_I.rot)
                s_next.sel = ~s_reg.sel;
              else if (PANEL_I.out_press)
              begin
                s_next.ui = s_reg.sel ? UI_MENU : UI_EDIT;
                s_next.sel = 1'b0;
              end
            end
            UI_EDIT:
            begin
              if (PANEL_I.menu_press)
                s_next.ui = UI_IDLE;
              else if (PANEL_I.rot)
                s_next.pref_edit = ~s_reg.pref_edit; // see R16
              else if (PANEL_I.out_press)
              begin
                s_next.pref = s_reg.pref_edit;
                s_next.ui = UI_WAIT; // see R17
                s_next.wait_cnt = `OEM_TW'(WAIT_CYC);
              end
            end
            UI_WAIT:
            begin
              if (s_reg.wait_cnt == '0)
              begin
                s_next.ui = UI_UTILITY_MENU_ITEM; // see R17
                s_next.sel = 1'b0;
              end
            end
            default: s_next.ui = UI_IDLE;
          endcase
        end
        else if ((s_reg.ui == UI_WAIT) & (s_reg.wait_cnt == '0))
          s_next.ui = UI_UTILITY_MENU_ITEM;

        if (fire & (AVS_ADDRESS_I == `OEM_REG_CTRL) & AVS_BYTEENABLE_I[0])
        begin
          s_next.inh_pol = AVS_WRITEDATA_I[`OEM_CTRL_INH_HIGH]; // see R20
          s_next.pref = AVS_WRITEDATA_I[`OEM_CTRL_PREF_FINE];
        end

        if (cmd_acc)
        begin
          if ((s_reg.mode != MODE_ANALOG) | is_cal)
            s_next.mode = MODE_DIGITAL; // see R6
          if ((s_reg.mode == MODE_ANALOG) & is_cal)
          begin
            s_next.out_req = s_reg.out_act; // see R10
            s_next.arm = 1'b0;
          end
          case (AVS_ADDRESS_I)
            `OEM_REG_CMD:
            begin
              if (code == `OEM_CMD_OUT_ON)
              begin
                if (inh)
                begin
                  s_next.rep_on = 1'b1; // see R22
                  s_next.rep_cnt = '0;
                  s_next.flash_cnt = `OEM_TW'(FLASH_CYC);
                end
                else
                  s_next.out_req = 1'b1;
              end
              else if (code == `OEM_CMD_OUT_OFF)
              begin
                s_next.out_req = 1'b0;
                s_next.rep_on = 1'b0;
              end
              else if (code == `OEM_CMD_UNLOCK)
                s_next.locked = 1'b0; // see R13
            end
            `OEM_REG_VSET: s_next.vset = merge_sp(s_reg.vset, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            `OEM_REG_ISET:
              s_next.iset = clamp_curr(merge_sp(s_reg.iset, AVS_WRITEDATA_I,
                                                AVS_BYTEENABLE_I)); // see R4
            default: s_next.rep_on = s_next.rep_on;
          endcase
        end
      end
      default: s_next.phase = PH_SETTLE;
    endcase

    if (s_next.ui != UI_EDIT)
      s_next.pref_edit = s_next.pref;
    // Inhibit acts in local and digital too, and a request must be renewed after it.
    if ((s_next.mode != MODE_ANALOG) & inh)
      s_next.out_req = 1'b0; // see R11
    if (~inh | (s_next.mode != MODE_DIGITAL))
      s_next.rep_on = 1'b0;
    s_next.out_act = (s_next.phase == PH_RUN)
                     & ((s_next.mode == MODE_ANALOG) ? (s_next.arm & ~inh) // see R23
                                                     : (s_next.out_req & ~inh)); // see R21

    if (s_next.phase != PH_RUN)
      s_next.disp = DISP_BLANK;
    else if (s_next.flash_cnt != '0)
      s_next.disp = DISP_INHIBIT;
    else if (s_next.locked)
    begin
      case (s_next.mode)
        MODE_ANALOG: s_next.disp = DISP_ANALOG_LOCKED; // see R12
        MODE_DIGITAL: s_next.disp = DISP_DIGITAL_LOCKED;
        default: s_next.disp = DISP_LOCK;
      endcase
    end
    else if (s_next.mode == MODE_ANALOG)
      s_next.disp = DISP_ANALOG_REMOTE;
    else if (s_next.mode == MODE_DIGITAL)
      s_next.disp = DISP_DIGITAL_REMOTE;
    else
    begin
      case (s_next.ui)
        UI_SET: s_next.disp = DISP_SET;
        UI_MENU: s_next.disp = s_next.sel ? DISP_EXIT : DISP_UTILITY;
        UI_UTILITY_MENU_ITEM: s_next.disp = s_next.sel ? DISP_MENU_BACK : DISP_KNOB_PREF;
        UI_EDIT: s_next.disp = DISP_PREF_EDIT;
        UI_WAIT: s_next.disp = DISP_WAIT;
        default: s_next.disp = DISP_BLANK; // see R5
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      s_reg <= '0;
    else if (CE_I)
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~s_reg.bus_done;
  assign AVS_READDATA_O = s_reg.rdata;
  assign OUT_EN_O = s_reg.out_act;
  assign MODE_O = s_reg.mode;
  assign DISP_O = s_reg.disp;
  assign PREF_SHOWN_O = s_reg.pref_edit;
  assign VSET_O = s_reg.vset;
  assign ISET_O = s_reg.iset;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);

  boot_output_off_a: assert property ( // see R1
    (CE_I && s_reg.phase == PH_BOOT && STRAP_I.self_test_ok && s_reg.syn_ms2
     && !STRAP_I.auto_rec) |=> (s_reg.ui == UI_SET && !OUT_EN_O && MODE_O == MODE_LOCAL))
    else $error("power-up did not leave output off in setpoint mode");

  current_floor_a: assert property ( // see R4
    (s_reg.phase == PH_RUN) |-> (ISET_O >= MIN_CURR))
    else $error("current setpoint below minimum");

  inhibit_off_a: assert property ( // see R21
    (CE_I && s_reg.phase == PH_RUN && inh && s_reg.mode != MODE_ANALOG && !cmd_hit
     && !PANEL_I.both) |=> (!OUT_EN_O && !s_reg.out_req))
    else $error("output on while inhibited");

  setpoint_no_on_a: assert property ( // see R19
    (CE_I && s_reg.phase == PH_RUN && s_reg.ui == UI_SET && s_reg.mode == MODE_LOCAL
     && !s_reg.out_req && !fire) |=> !s_reg.out_req)
    else $error("output enabled from setpoint mode");

  lock_holds_a: assert property ( // see R12
    (CE_I && s_reg.locked && s_reg.mode != MODE_LOCAL && PANEL_I.both)
    |=> (MODE_O == $past(MODE_O)) || $past(cmd_acc))
    else $error("locked panel restored local mode");

  analog_reject_a: assert property ( // see R9
    (CE_I && s_reg.mode == MODE_ANALOG && fire && AVS_ADDRESS_I == `OEM_REG_VSET)
    |=> $stable(VSET_O))
    else $error("analog remote accepted a setpoint command");

  cal_exit_a: assert property ( // see R10
    (CE_I && s_reg.mode == MODE_ANALOG && fire && is_cal) |=> (MODE_O == MODE_DIGITAL))
    else $error("calibration did not force digital remote");

  analog_follow_a: assert property ( // see R23
    (CE_I && s_reg.mode == MODE_ANALOG && s_reg.arm && !fire && !PANEL_I.both)
    |=> (OUT_EN_O == !$past(inh)))
    else $error("analog output does not follow inhibit");

  pref_wait_a: assert property ( // see R17
    (CE_I && s_reg.ui == UI_WAIT && s_reg.wait_cnt == '0) |=> (s_reg.ui == UI_UTILITY_MENU_ITEM))
    else $error("wait indication did not return to preference item");

endmodule

/* File: core/oem_cfg.svh */
`ifndef OEM_CFG_SVH
`define OEM_CFG_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define OEM_CLK_KHZ 125000
`define OEM_REP_MS 2000
`define OEM_FLASH_MS 1000
`define OEM_WAIT_MS 500
`define OEM_TW 28

// ----------------------------------------------------------------------
// Setpoints
// ----------------------------------------------------------------------
`define OEM_SPW 16
`define OEM_MIN_CURR 16'h0010
`define OEM_FINE_STEP 16'h0001
`define OEM_COARSE_STEP 16'h0064
`define OEM_ZERO_SP 16'h0000

// ----------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------
`define OEM_AW 5
`define OEM_REG_CTRL 5'h00
`define OEM_REG_STAT 5'h04
`define OEM_REG_CMD 5'h08
`define OEM_REG_VSET 5'h0c
`define OEM_REG_ISET 5'h10
`define OEM_CTRL_INH_HIGH 0
`define OEM_CTRL_PREF_FINE 1
`define OEM_CMDW 8
`define OEM_CMD_OUT_ON 8'h01
`define OEM_CMD_OUT_OFF 8'h02
`define OEM_CMD_UNLOCK 8'h03
`define OEM_CMD_CAL 8'h04

`endif

/* File: core/oem_pkg.sv */
`include "oem_cfg.svh"

package oem_pkg;

  typedef enum logic [1:0] {MODE_LOCAL, MODE_DIGITAL, MODE_ANALOG} oem_mode_type;

  typedef enum logic [1:0] {PH_SETTLE, PH_SYNC, PH_BOOT, PH_RUN} oem_phase_type;

  typedef enum logic [2:0] {UI_SET, UI_IDLE, UI_MENU, UI_UTILITY_MENU_ITEM, UI_EDIT, UI_WAIT} oem_ui_type;

  typedef enum logic [3:0] {DISP_BLANK, DISP_SET, DISP_DIGITAL_REMOTE, DISP_ANALOG_REMOTE,
    DISP_LOCK, DISP_ANALOG_LOCKED, DISP_DIGITAL_LOCKED, DISP_INHIBIT, DISP_UTILITY,
    DISP_EXIT, DISP_KNOB_PREF, DISP_PREF_EDIT, DISP_MENU_BACK, DISP_WAIT} oem_disp_type;

  typedef struct packed {
    logic vtap;
    logic itap;
    logic both;
    logic rot;
    logic rot_up;
    logic rot_curr;
    logic pushed;
    logic out_press;
    logic menu_press;
  } oem_panel_type;

  typedef struct packed {
    logic self_test_ok;
    logic sw_recall;
    logic sw_lock;
    logic auto_rec;
    logic [`OEM_SPW-1:0] saved_v;
    logic [`OEM_SPW-1:0] saved_i;
  } oem_strap_type;

  typedef struct packed {
    logic [22:0] zero;
    oem_mode_type mode;
    logic out_en;
    logic locked;
    logic setpoint;
    logic inhibit;
    logic rep_flash;
    logic pref_fine;
    logic inh_high;
  } oem_status_type;

  typedef struct packed {
    oem_phase_type phase;
    oem_mode_type mode;
    oem_ui_type ui;
    oem_disp_type disp;
    logic syn_inh1;
    logic syn_inh2;
    logic syn_ms1;
    logic syn_ms2;
    logic locked;
    logic out_req;
    logic arm;
    logic out_act;
    logic pref;
    logic pref_edit;
    logic inh_pol;
    logic sel;
    logic rep_on;
    logic [`OEM_TW-1:0] rep_cnt;
    logic [`OEM_TW-1:0] flash_cnt;
    logic [`OEM_TW-1:0] wait_cnt;
    logic [`OEM_SPW-1:0] vset;
    logic [`OEM_SPW-1:0] iset;
    logic bus_done;
    logic [31:0] rdata;
  } oem_state_type;

endpackage

/* File: dv/oem_far_model.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Analog connector far side
// ----------------------------------------------------------------------
// An undriven pin reads high, as the pull-up on the connector would make it.
module oem_far_model
(
  input wire logic inh_drive_i,
  input wire logic inh_level_i,
  input wire logic ms_ground_i,
  output logic inhibit_pin_o,
  output logic mode_sel_pin_o
);
  assign inhibit_pin_o = inh_drive_i ? inh_level_i : 1'b1;
  assign mode_sel_pin_o = ms_ground_i ? 1'b0 : 1'b1;
endmodule

/* File: dv/tb.sv */
`timescale 1ns/10ps
`include "oem_cfg.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module tb;
  import oem_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  oem_panel_type panel = '0;
  oem_strap_type strap = '{self_test_ok: 1'b1, default: '0};
  logic inh_drive = 1'b0;
  logic inh_level = 1'b1;
  logic ms_ground = 1'b0;
  logic inh_pin, ms_pin, wait_o, out_en, pref;
  logic [4:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata, q;
  oem_mode_type mode;
  oem_disp_type disp;
  logic [15:0] vset, iset;
  int errors = 0;
  int total_checks = 0;

  always #4 clk = ~clk;

  oem_far_model oem_far_model_i (.inh_drive_i(inh_drive), .inh_level_i(inh_level),
    .ms_ground_i(ms_ground), .inhibit_pin_o(inh_pin), .mode_sel_pin_o(ms_pin));

  oem_ctrl #(.REP_CYC(40), .FLASH_CYC(8), .WAIT_CYC(6)) oem_ctrl_i (.CORE_CLK_I(clk),
    .RST_I(rst), .CE_I(1'b1), .PANEL_I(panel), .STRAP_I(strap), .MODE_SEL_I(ms_pin),
    .INHIBIT_INPUT_I(inh_pin), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_o), .OUT_EN_O(out_en), .MODE_O(mode), .DISP_O(disp),
    .PREF_SHOWN_O(pref), .VSET_O(vset), .ISET_O(iset));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic press(input logic [8:0] p);
    @(posedge clk);
    panel <= oem_panel_type'(p);
    @(posedge clk);
    panel <= '0;
    cyc(2);
  endtask

  // The request is held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wait_o !== 1'b0)
      @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    cyc(1);
  endtask

  task automatic pin(input logic drv, input logic lvl);
    @(posedge clk);
    inh_drive <= drv;
    inh_level <= lvl;
    cyc(5);
  endtask

  task automatic boot(input logic gnd);
    @(posedge clk);
    rst <= 1'b1;
    ms_ground <= gnd;
    inh_drive <= 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(8);
  endtask

  task automatic t_powerup;
    `CHK("out_en", 1'b0, out_en);
    `CHK("disp", DISP_SET, disp);
    `CHK("mode", MODE_LOCAL, mode);
    `CHK("vset", 16'h0000, vset);
    `CHK("iset", 16'h0010, iset);
    press(9'h001);
    `CHK("disp", DISP_SET, disp);
    press(9'h100);
    `CHK("disp", DISP_BLANK, disp);
  endtask

  task automatic t_menu;
    press(9'h001);
    `CHK("disp", DISP_UTILITY, disp);
    press(9'h020);
    `CHK("disp", DISP_EXIT, disp);
    press(9'h020);
    press(9'h002);
    `CHK("disp", DISP_KNOB_PREF, disp);
    press(9'h002);
    press(9'h020);
    `CHK("disp", DISP_PREF_EDIT, disp);
    `CHK("pref", 1'b1, pref);
    press(9'h002);
    `CHK("disp", DISP_WAIT, disp);
    cyc(8);
    `CHK("disp", DISP_KNOB_PREF, disp);
    `CHK("pref", 1'b1, pref);
    press(9'h020);
    press(9'h002);
    `CHK("disp", DISP_UTILITY, disp);
    press(9'h001);
    `CHK("disp", DISP_BLANK, disp);
    press(9'h100);
    press(9'h030);
    `CHK("vset", 16'h0001, vset);
    press(9'h034);
    `CHK("vset", 16'h0065, vset);
    press(9'h100);
  endtask

  task automatic t_output;
    press(9'h002);
    `CHK("out_en", 1'b1, out_en);
    press(9'h100);
    press(9'h002);
    `CHK("out_en", 1'b0, out_en);
    press(9'h002);
    `CHK("out_en", 1'b0, out_en);
    press(9'h080);
    press(9'h002);
    press(9'h002);
    `CHK("out_en", 1'b0, out_en);
  endtask

  task automatic t_inhibit;
    bus(1'b1, `OEM_REG_CTRL, 32'h0000_0001);
    cyc(4);
    press(9'h002);
    `CHK("out_en", 1'b0, out_en);
    `CHK("disp", DISP_INHIBIT, disp);
    bus(1'b0, `OEM_REG_STAT, 32'h0);
    `CHK("stat", 2'b11, {q[3], q[0]});
    bus(1'b1, `OEM_REG_CTRL, 32'h0000_0000);
    cyc(4);
    press(9'h002);
    `CHK("out_en", 1'b1, out_en);
    pin(1'b1, 1'b0);
    `CHK("out_en", 1'b0, out_en);
    pin(1'b0, 1'b1);
    `CHK("out_en", 1'b0, out_en);
  endtask

  task automatic t_digital;
    bus(1'b1, `OEM_REG_CMD, 32'h1);
    `CHK("mode", MODE_DIGITAL, mode);
    `CHK("disp", DISP_DIGITAL_REMOTE, disp);
    `CHK("out_en", 1'b1, out_en);
    press(9'h002);
    `CHK("out_en", 1'b1, out_en);
    press(9'h040);
    `CHK("mode", MODE_LOCAL, mode);
    bus(1'b1, `OEM_REG_ISET, 32'h5);
    `CHK("mode", MODE_DIGITAL, mode);
    `CHK("iset", 16'h0010, iset);
    bus(1'b0, 5'h14, 32'h0);
    `CHK("unmapped", 32'h0, q);
    bus(1'b1, `OEM_REG_CMD, 32'h2);
    `CHK("out_en", 1'b0, out_en);
    pin(1'b1, 1'b0);
    bus(1'b1, `OEM_REG_CMD, 32'h1);
    `CHK("out_en", 1'b0, out_en);
    `CHK("disp", DISP_INHIBIT, disp);
    cyc(20);
    `CHK("disp", DISP_DIGITAL_REMOTE, disp);
    cyc(22);
    `CHK("disp", DISP_INHIBIT, disp);
  endtask

  task automatic t_analog;
    boot(1'b1);
    `CHK("mode", MODE_ANALOG, mode);
    `CHK("disp", DISP_ANALOG_REMOTE, disp);
    `CHK("out_en", 1'b1, out_en);
    bus(1'b1, `OEM_REG_VSET, 32'h1234);
    bus(1'b0, `OEM_REG_VSET, 32'h0);
    `CHK("vset", 32'h0, q);
    `CHK("mode", MODE_ANALOG, mode);
    pin(1'b1, 1'b0);
    `CHK("out_en", 1'b0, out_en);
    pin(1'b0, 1'b1);
    `CHK("out_en", 1'b1, out_en);
    bus(1'b1, `OEM_REG_CMD, 32'h4);
    `CHK("mode", MODE_DIGITAL, mode);
  endtask

  task automatic t_lock;
    @(posedge clk);
    strap <= '{self_test_ok: 1'b1, sw_recall: 1'b1, sw_lock: 1'b1, saved_v: 16'h0123,
               default: '0};
    boot(1'b0);
    `CHK("vset", 16'h0123, vset);
    `CHK("disp", DISP_LOCK, disp);
    press(9'h002);
    `CHK("out_en", 1'b0, out_en);
    bus(1'b1, `OEM_REG_CMD, 32'h2);
    `CHK("disp", DISP_DIGITAL_LOCKED, disp);
    press(9'h040);
    `CHK("mode", MODE_DIGITAL, mode);
    bus(1'b1, `OEM_REG_CMD, 32'h3);
    `CHK("disp", DISP_DIGITAL_REMOTE, disp);
    press(9'h040);
    `CHK("mode", MODE_LOCAL, mode);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    boot(1'b0);
    t_powerup();
    t_menu();
    t_output();
    t_inhibit();
    t_digital();
    t_analog();
    t_lock();
    results();
  end

  // The scenarios need a few hundred cycles, so this limit leaves wide margin.
  initial
  begin
    #100000;
    errors++;
    results();
  end
endmodule
